/* inc/rws_pkg.sv */
// reset and wake sequencer constants: timing, vectors, status bit positions
// assumes a 40 MHz system clock and the 8-bit register sizes of the core
package rws_pkg;

    // ------------------------------------------------------------------
    // clock and timer figures
    // ------------------------------------------------------------------
    localparam int RWS_CLK_HZ = 40000000;
    localparam int RWS_PWR_DELAY_MS = 64;
    // least time rounds up; 64 ms is an exact cycle count anyway
    localparam longint RWS_PWR_DELAY_CYC =
        (longint'(RWS_PWR_DELAY_MS) * RWS_CLK_HZ + 999) / 1000;
    localparam int RWS_OSC_START_CYC = 1024; // oscillator cycles to count

    // ------------------------------------------------------------------
    // vectors and bit positions
    // ------------------------------------------------------------------
    localparam logic [12:0] RWS_RESET_VECTOR = 13'h0000;
    localparam logic [12:0] RWS_IRQ_VECTOR = 13'h0004;
    localparam int RWS_BROWN_OUT_BIT = 0;
    localparam logic [7:0] RWS_ZERO_BYTE = 8'h00;
    localparam logic [7:0] RWS_STATUS_RESET = 8'h01; // brown-out flag idle high

    // ------------------------------------------------------------------
    // sequencer states and reset causes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        RWS_ST_POWER_TIMER,
        RWS_ST_OSC_TIMER,
        RWS_ST_RUN,
        RWS_ST_SLEEP,
        RWS_ST_WAKE
    } rws_state_t;

    typedef enum logic [1:0] {
        RWS_CAUSE_POWER_ON,
        RWS_CAUSE_BROWN_OUT,
        RWS_CAUSE_PIN,
        RWS_CAUSE_WATCHDOG
    } rws_cause_t;

endpackage : rws_pkg

/* rtl/rws_delay_timer.sv */
// down-counting delay timer used for the power and oscillator delays
// assumes start is a one-cycle pulse; done stays high until next start
`timescale 1ns/10ps
module rws_delay_timer
#(
    parameter int WIDTH = 32
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // control
    input wire logic i_start,
    input wire logic [WIDTH-1:0] i_count,
    input wire logic i_tick,
    // status
    output logic o_done
);

    logic [WIDTH-1:0] remain;

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    // load on start, count ticks down to zero
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            remain <= '0;
            o_done <= 1'b0;
        end
        else if (i_start)
        begin
            remain <= i_count;
            o_done <= 1'b0;
        end
        else if (!o_done && i_tick)
        begin
            if (remain <= WIDTH'(1))
                o_done <= 1'b1;
            remain <= (remain == '0) ? remain : remain - WIDTH'(1);
        end
    end

endmodule : rws_delay_timer

/* rtl/rws_sequencer.sv */
// reset and wake sequencer: holds the core in reset, handles sleep wake-up
// assumes detector inputs are synchronous levels and sleep is a pulse
`timescale 1ns/10ps
// What this block does
// (R1) After power-on the core is held in reset for the 64 ms power delay.
// (R2) The core stays in reset until the oscillator start timer has run out.
// (R3) A brown-out resets the device, optionally stretched by the 64 ms delay.
// (R4) Sleep is left only on a pin, power-on or brown-out reset, a watchdog time-out or an interrupt.
// (R5) An interrupt wake with global enable set loads the PC with 0004h.
// (R6) Wake by interrupt or watchdog leaves registers unchanged.
// (R7) The interrupt flags that caused a wake are set and stay visible.
// (R8) A brown-out reset clears status bit 0; power-on reloads 01h; pin and watchdog resets leave it as is.
// (R9) Segment data is undefined after power-on, kept over other resets.
// (R10) A brown-out that drops the supply too low acts as a power-on reset.
// (R11) Execution starts from the reset vector only after every delay ends.
module rws_sequencer
    import rws_pkg::*;
#(
    parameter longint PWR_DELAY_CYC = RWS_PWR_DELAY_CYC,
    parameter int OSC_START_CYC = RWS_OSC_START_CYC
)
(
    // clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RESETN,
    // reset sources
    input wire logic I_POWER_ON,
    input wire logic I_BROWN_OUT,
    input wire logic I_SUPPLY_TOO_LOW,
    input wire logic I_EXTERNAL_RESET_PIN,
    input wire logic I_WATCHDOG_TIMER,
    // configuration
    input wire logic I_POWER_UP_TIMER_EN,
    input wire logic I_CRYSTAL_MODE,
    input wire logic I_OSC_TICK,
    // sleep and interrupts
    input wire logic I_SLEEP_REQ,
    input wire logic I_GLOBAL_INTERRUPT_ENABLE,
    input wire logic [7:0] I_IRQ_ENABLE,
    input wire logic [7:0] I_IRQ_PENDING,
    // register port
    input wire logic [1:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    // core control
    output logic O_CORE_RESET,
    output logic O_SLEEPING,
    output logic O_PC_LOAD,
    output logic [12:0] O_PC_VALUE,
    output logic O_INIT_POWER_ON,
    output logic O_INIT_RESET,
    output logic O_SEGMENT_CLEAR_X,
    output logic O_IRQ
);

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [1:0] ADDR_STATUS = 2'h0;
    localparam logic [1:0] ADDR_WAKE_FLAGS = 2'h1;
    localparam logic [1:0] ADDR_EVENT = 2'h2;
    localparam logic [1:0] ADDR_MASK = 2'h3;
    localparam int PWR_W = 32;

    rws_state_t state;
    rws_cause_t cause;
    logic any_reset;
    logic power_like;
    logic timer_start;
    logic osc_start;
    logic pwr_done;
    logic osc_done;
    logic use_pwr;
    logic [7:0] reset_status;
    logic [7:0] wake_flags;
    logic [7:0] event_flags;
    logic [7:0] event_mask;
    logic [3:0] event_set;
    logic wake_irq;
    logic wake_wdt;

    // ------------------------------------------------------------------
    // reset decode
    // ------------------------------------------------------------------
    // low supply during brown-out is treated as a full power-on
    assign power_like = I_POWER_ON | (I_BROWN_OUT & I_SUPPLY_TOO_LOW); // R10
    assign any_reset = power_like | I_BROWN_OUT | I_EXTERNAL_RESET_PIN
        | (I_WATCHDOG_TIMER & (state != RWS_ST_SLEEP));
    assign wake_irq = (state == RWS_ST_SLEEP)
        && ((I_IRQ_ENABLE & I_IRQ_PENDING) != RWS_ZERO_BYTE); // R4
    assign wake_wdt = (state == RWS_ST_SLEEP) && I_WATCHDOG_TIMER; // R4
    assign timer_start = any_reset;
    assign osc_start = (state == RWS_ST_POWER_TIMER) && pwr_done
        && !any_reset;
    function automatic rws_cause_t decode_cause(input logic pwr,
        input logic bo, input logic pin);
        if (pwr)
            return RWS_CAUSE_POWER_ON;
        else if (bo)
            return RWS_CAUSE_BROWN_OUT;
        else if (pin)
            return RWS_CAUSE_PIN;
        else
            return RWS_CAUSE_WATCHDOG;
    endfunction : decode_cause

    // ------------------------------------------------------------------
    // delay timers
    // ------------------------------------------------------------------
    // power delay runs on the system clock, oscillator delay on osc ticks in crystal mode
    rws_delay_timer #(.WIDTH(PWR_W)) u_power_timer (
        .i_clk(I_SYS_CLK),
        .i_resetn(I_RESETN),
        .i_start(timer_start),
        .i_count(use_pwr ? PWR_W'(PWR_DELAY_CYC) : PWR_W'(1)),
        .i_tick(1'b1),
        .o_done(pwr_done)
    );
    rws_delay_timer #(.WIDTH(PWR_W)) u_osc_timer (
        .i_clk(I_SYS_CLK),
        .i_resetn(I_RESETN),
        .i_start(osc_start | timer_start),
        .i_count(I_CRYSTAL_MODE ? PWR_W'(OSC_START_CYC) : PWR_W'(1)),
        .i_tick(I_CRYSTAL_MODE ? I_OSC_TICK : 1'b1),
        .o_done(osc_done)
    );
    // power delay always on power-on; optional for brown-out only
    assign use_pwr = power_like
        || (I_BROWN_OUT && I_POWER_UP_TIMER_EN); // R1 R3

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    // the detector inputs pull back to the power state from anywhere
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            state <= RWS_ST_POWER_TIMER;
            cause <= RWS_CAUSE_POWER_ON;
        end
        else if (any_reset)
        begin
            state <= RWS_ST_POWER_TIMER; // R3
            cause <= decode_cause(power_like, I_BROWN_OUT,
                I_EXTERNAL_RESET_PIN);
        end
        else
        begin
            case (state)
                RWS_ST_POWER_TIMER:
                    if (pwr_done)
                        state <= RWS_ST_OSC_TIMER; // R1
                RWS_ST_OSC_TIMER:
                    if (osc_done && !osc_start)
                        state <= RWS_ST_RUN; // R2 R11
                RWS_ST_RUN:
                    if (I_SLEEP_REQ)
                        state <= RWS_ST_SLEEP;
                RWS_ST_SLEEP:
                    if (wake_irq || wake_wdt)
                        state <= RWS_ST_WAKE; // R4
                RWS_ST_WAKE:
                    state <= RWS_ST_RUN;
                default:
                    state <= RWS_ST_POWER_TIMER;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // core outputs
    // ------------------------------------------------------------------
    // reset held through every delay; init pulses on release only
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            O_CORE_RESET <= 1'b1;
            O_SLEEPING <= 1'b0;
            O_PC_LOAD <= 1'b0;
            O_PC_VALUE <= RWS_RESET_VECTOR;
            O_INIT_POWER_ON <= 1'b0;
            O_INIT_RESET <= 1'b0;
        end
        else
        begin
            O_CORE_RESET <= any_reset || (state == RWS_ST_POWER_TIMER)
                || (state == RWS_ST_OSC_TIMER && !(osc_done && !osc_start));
            O_SLEEPING <= (state == RWS_ST_SLEEP) && !wake_irq && !wake_wdt
                && !any_reset || (state == RWS_ST_RUN && I_SLEEP_REQ
                && !any_reset);
            O_PC_LOAD <= 1'b0;
            O_INIT_POWER_ON <= 1'b0;
            O_INIT_RESET <= 1'b0;
            if (!any_reset && state == RWS_ST_OSC_TIMER && osc_done
                && !osc_start)
            begin
                O_PC_LOAD <= 1'b1;
                O_PC_VALUE <= RWS_RESET_VECTOR; // R11
                O_INIT_POWER_ON <= (cause == RWS_CAUSE_POWER_ON); // R10
                O_INIT_RESET <= (cause != RWS_CAUSE_POWER_ON);
            end
            else if (!any_reset && wake_irq && I_GLOBAL_INTERRUPT_ENABLE)
            begin
                // registers untouched; only the vector is loaded
                O_PC_LOAD <= 1'b1; // R6
                O_PC_VALUE <= RWS_IRQ_VECTOR; // R5
            end
        end
    end

    // ------------------------------------------------------------------
    // segment data handling
    // ------------------------------------------------------------------
    // power-on and too-low brown-out mark segment data unknown; others keep it
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            O_SEGMENT_CLEAR_X <= 1'b1;
        else
            O_SEGMENT_CLEAR_X <= power_like; // R9
    end

    // ------------------------------------------------------------------
    // reset status and wake flags
    // ------------------------------------------------------------------
    // brown-out clears bit 0; software sets it back by a write
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            reset_status <= RWS_STATUS_RESET;
        else if (I_BROWN_OUT && !power_like)
            reset_status[RWS_BROWN_OUT_BIT] <= 1'b0; // R8
        else if (power_like)
            reset_status <= RWS_STATUS_RESET;
        else if (I_WR && I_ADDR == ADDR_STATUS)
            reset_status <= I_WDATA;
    end
    // flags that woke the core; the hardware set wins over a clear
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            wake_flags <= RWS_ZERO_BYTE;
        else if (wake_irq)
            wake_flags <= wake_flags | (I_IRQ_ENABLE & I_IRQ_PENDING); // R7
        else if (I_WR && I_ADDR == ADDR_WAKE_FLAGS)
            wake_flags <= wake_flags & ~I_WDATA;
    end

    // ------------------------------------------------------------------
    // interrupt events
    // ------------------------------------------------------------------
    assign event_set = {O_PC_LOAD && O_PC_VALUE == RWS_RESET_VECTOR,
        wake_wdt, wake_irq, any_reset};

    // sticky events; read clears, but a new event in that cycle survives
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            event_flags <= RWS_ZERO_BYTE;
        else if (I_RD && I_ADDR == ADDR_EVENT)
            event_flags <= {4'h0, event_set};
        else
            event_flags <= event_flags | {4'h0, event_set};
    end
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            event_mask <= RWS_ZERO_BYTE;
        else if (I_WR && I_ADDR == ADDR_MASK)
            event_mask <= I_WDATA;
    end
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            O_IRQ <= 1'b0;
        else
            O_IRQ <= ((event_flags | {4'h0, event_set}) & event_mask
                & ~((I_RD && I_ADDR == ADDR_EVENT) ? event_flags
                : RWS_ZERO_BYTE)) != RWS_ZERO_BYTE;
    end

    // ------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            O_RDATA <= RWS_ZERO_BYTE;
        else if (I_RD)
        begin
            case (I_ADDR)
                ADDR_STATUS: O_RDATA <= reset_status;
                ADDR_WAKE_FLAGS: O_RDATA <= wake_flags;
                ADDR_EVENT: O_RDATA <= event_flags;
                ADDR_MASK: O_RDATA <= event_mask;
                default: O_RDATA <= RWS_ZERO_BYTE;
            endcase
        end
        else
            O_RDATA <= RWS_ZERO_BYTE;
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence seq_release;
        state == RWS_ST_OSC_TIMER && osc_done && !osc_start && !any_reset;
    endsequence
    AST_RELEASE_VECTOR: assert property ( // R11
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        seq_release |=> O_PC_LOAD && O_PC_VALUE == RWS_RESET_VECTOR
            && !O_CORE_RESET)
        else $error("release without reset vector");
    AST_POWER_HOLD: assert property ( // R1
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        state == RWS_ST_POWER_TIMER |=> O_CORE_RESET)
        else $error("core left reset during power delay");
    AST_OSC_HOLD: assert property ( // R2
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        state == RWS_ST_OSC_TIMER && !osc_done |=> O_CORE_RESET)
        else $error("core left reset before oscillator stable");
    AST_BROWN_OUT_RESET: assert property ( // R3
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        I_BROWN_OUT |=> O_CORE_RESET ##1 O_CORE_RESET)
        else $error("brown-out did not hold reset");
    AST_SLEEP_STAY: assert property ( // R4
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        state == RWS_ST_SLEEP && !wake_irq && !wake_wdt && !any_reset
            |=> state == RWS_ST_SLEEP)
        else $error("sleep left without wake source");
    AST_IRQ_VECTOR: assert property ( // R5
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        wake_irq && I_GLOBAL_INTERRUPT_ENABLE && !any_reset
            |=> O_PC_LOAD && O_PC_VALUE == RWS_IRQ_VECTOR)
        else $error("interrupt wake missed vector");
    AST_WAKE_NO_INIT: assert property ( // R6
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        (wake_irq || wake_wdt) && !any_reset
            |=> !O_INIT_RESET && !O_INIT_POWER_ON)
        else $error("wake reinitialised registers");
    AST_WAKE_FLAG: assert property ( // R7
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        wake_irq |=> (wake_flags & $past(I_IRQ_PENDING & I_IRQ_ENABLE))
            == $past(I_IRQ_PENDING & I_IRQ_ENABLE))
        else $error("wake source flag not set");
    AST_BROWN_OUT_BIT: assert property ( // R8
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        I_BROWN_OUT && !power_like |=> !reset_status[RWS_BROWN_OUT_BIT])
        else $error("brown-out bit not cleared");
    AST_SEGMENT_KEEP: assert property ( // R9
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        (I_EXTERNAL_RESET_PIN || I_WATCHDOG_TIMER) && !power_like
            |=> !O_SEGMENT_CLEAR_X)
        else $error("segment data lost on warm reset");
    AST_LOW_SUPPLY: assert property ( // R10
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        I_BROWN_OUT && I_SUPPLY_TOO_LOW |=> O_SEGMENT_CLEAR_X
            && cause == RWS_CAUSE_POWER_ON)
        else $error("low supply not treated as power-on");

endmodule : rws_sequencer

/* dv/rws_sequencer_test.sv */
// self-checking bench for the reset and wake sequencer
// assumes shortened delays and one oscillator tick every fourth clock
`timescale 1ns/10ps
module rws_sequencer_test;
    import rws_pkg::*;

    // ------------------------------------------------------------
    // settings and signals
    // ------------------------------------------------------------
    localparam longint PWR = 20; // short power delay keeps the run brief
    localparam int OSC = 4;
    localparam int TICK = 4; // clocks per oscillator tick
    localparam int LIMIT = 20000;
    logic clk = 1'b0;
    logic rst_n, pon, bo, low, pin, wdt, pwr_en, xtal, tick, slp, global_interrupt_enable;
    logic [7:0] en, pend, wdat, rdat;
    logic [1:0] addr;
    logic [1:0] tick_cnt = 2'h0;
    logic wr_s, rd_s, core_rst, sleeping, pc_load, init_pon, init_rst;
    logic seg_x, irq;
    logic [12:0] pc_val, pc_got;
    logic pc_seen, rst_seen, seg_seen, ip_seen, ir_seen;
    logic [15:0] lfsr = 16'ha7e6;
    int err_count = 0;
    int cmp_count = 0;
    int cycles = 0;

    rws_sequencer #(.PWR_DELAY_CYC(PWR), .OSC_START_CYC(OSC)) rws_sequencer_i
    (
        .I_SYS_CLK(clk), .I_RESETN(rst_n), .I_POWER_ON(pon),
        .I_BROWN_OUT(bo), .I_SUPPLY_TOO_LOW(low),
        .I_EXTERNAL_RESET_PIN(pin), .I_WATCHDOG_TIMER(wdt),
        .I_POWER_UP_TIMER_EN(pwr_en), .I_CRYSTAL_MODE(xtal),
        .I_OSC_TICK(tick), .I_SLEEP_REQ(slp),
        .I_GLOBAL_INTERRUPT_ENABLE(global_interrupt_enable), .I_IRQ_ENABLE(en),
        .I_IRQ_PENDING(pend), .I_ADDR(addr), .I_WDATA(wdat), .I_WR(wr_s),
        .I_RD(rd_s), .O_RDATA(rdat), .O_CORE_RESET(core_rst),
        .O_SLEEPING(sleeping), .O_PC_LOAD(pc_load), .O_PC_VALUE(pc_val),
        .O_INIT_POWER_ON(init_pon), .O_INIT_RESET(init_rst),
        .O_SEGMENT_CLEAR_X(seg_x), .O_IRQ(irq)
    );

    // ------------------------------------------------------------
    // clock, oscillator ticks, monitors, timeout
    // ------------------------------------------------------------
    always #12.5 clk = ~clk;

    // free-running tick so crystal counts see a slow oscillator
    always @(posedge clk)
    begin
        tick_cnt <= tick_cnt + 2'h1;
        tick <= (tick_cnt == 2'h3);
    end

    // sticky witnesses; sampled mid-cycle, clear of the launching edge
    always @(negedge clk)
    begin
        if (pc_load === 1'b1)
        begin
            pc_seen = 1'b1;
            pc_got = pc_val;
        end
        if (core_rst === 1'b1) rst_seen = 1'b1;
        if (seg_x === 1'b1) seg_seen = 1'b1;
        if (init_pon === 1'b1) ip_seen = 1'b1;
        if (init_rst === 1'b1) ir_seen = 1'b1;
        cycles++;
        if (cycles == LIMIT)
        begin
            err_count++;
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // tasks and functions
    // ------------------------------------------------------------
    function automatic logic [15:0] nxt(input logic [15:0] s);
        nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nxt

    // status after a reset kind: brown-out clears bit 0, too-low acts
    // like power-on, the rest keep the previous value
    function automatic logic [7:0] exp_status(input int k,
                                              input logic [7:0] prev);
        if (k == 4) exp_status = RWS_STATUS_RESET;
        else if (k >= 2) exp_status = prev & 8'hfe;
        else exp_status = prev;
    endfunction : exp_status

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    task automatic clr();
        {pc_seen, rst_seen, seg_seen, ip_seen, ir_seen} = 5'h0;
    endtask : clr

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        // data launched by the previous edge still stands here
        @(posedge clk);
        v = rdat;
    endtask : rd

    // one-cycle reset source pulse, then count clocks to release
    task automatic kick(input int k, output int n);
        @(posedge clk);
        clr();
        case (k)
            0: pin <= 1'b1;
            1: wdt <= 1'b1;
            5: pon <= 1'b1;
            default: {bo, low} <= {1'b1, k == 4};
        endcase
        @(posedge clk);
        {pin, wdt, pon, bo, low} <= 5'h0;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
            if (n == 2) chk(core_rst, 1'b1);
        end
        while (pc_load !== 1'b1 && n < 500);
    endtask : kick

    task automatic go_sleep();
        @(posedge clk);
        slp <= 1'b1;
        @(posedge clk);
        slp <= 1'b0;
        @(posedge clk);
        chk(sleeping, 1'b1);
        clr();
    endtask : go_sleep

    task automatic wait_wake();
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (sleeping !== 1'b0 && n < 50);
        chk(16'(n < 50), 16'h1);
    endtask : wait_wake

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        int n;
        logic [7:0] v, st, pv, ev, m;
        {rst_n, pon, bo, low, pin, wdt, pwr_en, slp, global_interrupt_enable} = 9'h0;
        {xtal, wr_s, rd_s, en, pend, wdat, addr} = 29'h0;
        clr();
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        // power-on with crystal: both delays must run out first
        xtal <= 1'b1;
        kick(5, n);
        chk(16'(n >= PWR), 16'h1);
        chk(16'(n >= PWR + (OSC - 1) * TICK), 16'h1);
        chk({pc_seen, 2'h0, pc_got}, {1'b1, 2'h0, RWS_RESET_VECTOR});
        chk(ip_seen, 1'b1);
        rd(2'h0, st);
        chk(st, RWS_STATUS_RESET);
        xtal <= 1'b0;
        // pin, watchdog, brown-out with and without delay, too-low supply
        for (int k = 0; k < 5; k++)
        begin
            wr(2'h0, 8'h01);
            pwr_en <= (k == 2);
            kick(k, n);
            rd(2'h0, v);
            chk(v, exp_status(k, 8'h01));
            if (k == 2) chk(16'(n >= PWR), 16'h1);
            if (k == 3) chk(16'(n < PWR), 16'h1);
            chk({ip_seen, seg_seen}, {2{k == 4}});
            chk(ir_seen, k != 4);
        end
        pwr_en <= 1'b0;
        rd(2'h2, ev);
        chk(ev, 8'h09);
        // interrupt wakes with random enables, global enable alternating
        for (int i = 0; i < 4; i++)
        begin
            lfsr = nxt(lfsr);
            pv = lfsr[7:0] | (8'h01 << lfsr[10:8]);
            go_sleep();
            pend <= pv;
            en <= ~pv;
            global_interrupt_enable <= i[0];
            repeat (6) @(posedge clk);
            chk(sleeping, 1'b1);
            m = (lfsr[15:8] | (8'h01 << lfsr[10:8])) & pv;
            en <= lfsr[15:8] | (8'h01 << lfsr[10:8]);
            wait_wake();
            repeat (2) @(posedge clk);
            chk(pc_seen, i[0]);
            if (i[0]) chk(pc_got, RWS_IRQ_VECTOR);
            chk(rst_seen, 1'b0);
            rd(2'h1, v);
            chk(v & m, m);
            pend <= 8'h00;
            en <= 8'h00;
            wr(2'h1, 8'hff);
            rd(2'h1, v);
            chk(v, 8'h00);
        end
        // watchdog wake, then the interrupt output through its mask
        rd(2'h2, ev);
        chk(ev, 8'h02);
        go_sleep();
        wdt <= 1'b1;
        @(posedge clk);
        wdt <= 1'b0;
        wait_wake();
        repeat (2) @(posedge clk);
        chk({rst_seen, pc_seen}, 2'h0);
        wr(2'h3, 8'h04);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        wr(2'h3, 8'h00);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        wr(2'h3, 8'h04);
        rd(2'h2, ev);
        chk(ev, 8'h04);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        // pin reset taken straight out of sleep
        go_sleep();
        kick(0, n);
        chk({sleeping, ir_seen}, 2'h1);
        end_sim();
    end

endmodule : rws_sequencer_test
